/* File: pkg/rtcc_defs.svh */
// offsets, field positions, reset values and masks for the calendar block
`ifndef RTCC_DEFS_SVH
`define RTCC_DEFS_SVH

// register byte offsets on the bus
`define RTCC_OFS_HOUR_MINUTE   8'h00
`define RTCC_OFS_MONTH_DAY     8'h04
`define RTCC_OFS_YEAR_WEEKDAY  8'h08
`define RTCC_OFS_IRQ_FLAGS     8'h0C
`define RTCC_OFS_IRQ_ENABLES   8'h10

// hour/minute field positions
`define RTCC_PM_BIT            14
`define RTCC_HOUR_TENS_LSB     12
`define RTCC_HOUR_UNITS_LSB    8
`define RTCC_MIN_TENS_LSB      4
`define RTCC_MIN_UNITS_LSB     0

// month/day and year/weekday field positions
`define RTCC_MONTH_TENS_BIT    12
`define RTCC_MONTH_UNITS_LSB   8
`define RTCC_DAY_TENS_LSB      4
`define RTCC_DAY_UNITS_LSB     0
`define RTCC_WEEKDAY_LSB       8
`define RTCC_YEAR_TENS_LSB     4
`define RTCC_YEAR_UNITS_LSB    0

// reset values of the counters
`define RTCC_RST_HOUR_TENS     2'h1
`define RTCC_RST_HOUR_UNITS    4'h2
`define RTCC_RST_MONTH_UNITS   4'h1
`define RTCC_RST_DAY_UNITS     4'h1

// flag bit positions
`define RTCC_FLAG_REGULATION   15
`define RTCC_FLAG_SW1HZ        14
`define RTCC_FLAG_SW10HZ       13
`define RTCC_FLAG_SW100HZ      12
`define RTCC_FLAG_ALARM        8
`define RTCC_FLAG_DAY          7
`define RTCC_FLAG_HOUR         6
`define RTCC_FLAG_MINUTE       5
`define RTCC_FLAG_SECOND       4
`define RTCC_FLAG_HALF         3
`define RTCC_FLAG_QUARTER      2
`define RTCC_FLAG_EIGHTH       1
`define RTCC_FLAG_THIRTYSECOND 0

// implemented flag and enable bits, reserved bits 11-9 read zero
`define RTCC_FLAG_MASK         16'hF1FF

// weekday range
`define RTCC_WEEKDAY_SUNDAY    3'h0
`define RTCC_WEEKDAY_SATURDAY  3'h6

// axi responses
`define RTCC_RESP_OKAY         2'h0
`define RTCC_RESP_SLVERR       2'h2

`endif

/* File: pkg/rtcc_pkg.sv */
// types shared by the calendar block
package rtcc_pkg;

   // time of day fields
   typedef struct packed {
      logic       pm;
      logic [1:0] hour_tens;
      logic [3:0] hour_units;
      logic [2:0] minute_tens;
      logic [3:0] minute_units;
   } rtcc_time_s;

   // date fields
   typedef struct packed {
      logic       month_tens;
      logic [3:0] month_units;
      logic [1:0] day_tens;
      logic [3:0] day_units;
   } rtcc_date_s;

   // year and day of week
   typedef struct packed {
      logic [2:0] weekday_count;
      logic [3:0] year_tens;
      logic [3:0] year_units;
   } rtcc_year_s;

   // one-cycle event pulses from the rest of the clock unit
   typedef struct packed {
      logic regulation_done;
      logic stopwatch_1hz;
      logic stopwatch_10hz;
      logic stopwatch_100hz;
      logic alarm_match;
      logic minute_step;
      logic second_tick;
      logic half_second;
      logic quarter_second;
      logic eighth_second;
      logic thirtysecond_second;
   } rtcc_events_s;

   // register select
   typedef enum logic [2:0] {
      RTCC_SEL_NONE,
      RTCC_SEL_HOUR_MINUTE,
      RTCC_SEL_MONTH_DAY,
      RTCC_SEL_YEAR_WEEKDAY,
      RTCC_SEL_FLAGS,
      RTCC_SEL_ENABLES
   } rtcc_sel_e;

endpackage : rtcc_pkg

/* File: hdl/rtcc_calendar.sv */
// calendar counters, interrupt flags and enables behind an axi4-lite slave
// Summary of operation
// R1 - pm indicator at bit 14 in 12-hour mode
// R2 - 24-hour mode writes clear pm unless pm is already set and written as one
// R3 - pm clears at next hour step after switch
// R4 - hour bcd, 1-12 or 0-23
// R5 - minute bcd 0 to 59
// R6 - software avoids digit writes while busy
// R7 - month bcd 1 to 12
// R8 - day bcd, limit follows month and leap
// R9 - weekday counts modulo seven, 0 to 6
// R10 - weekday zero is sunday, six saturday
// R11 - year two bcd digits 0 to 99
// R12 - flags sticky, cleared by writing one
// R13 - upper flags regulation and stopwatch, 11-9 zero
// R14 - lower flags alarm down to 1/32 second
// R15 - one enable per flag, same position
// R16 - enable written one enables, zero disables
// R17 - irq high when flag and enable set
// R18 - carries minute to hour, day, month, year
`timescale 1ns/100ps
`default_nettype none
`include "rtcc_defs.svh"

module rtcc_calendar
   import rtcc_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              reset,
   // axi4-lite write address
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic [2:0]        awprot,
   // axi4-lite write data
   input  wire logic              wvalid,
   output logic                   wready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   // axi4-lite write response
   output logic                   bvalid,
   input  wire logic              bready,
   output logic [1:0]             bresp,
   // axi4-lite read address
   input  wire logic              arvalid,
   output logic                   arready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic [2:0]        arprot,
   // axi4-lite read data
   output logic                   rvalid,
   input  wire logic              rready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   // links to the rest of the clock unit
   input  wire logic              hour24_select,
   input  wire logic              clock_busy_status,
   input  wire rtcc_events_s      events,
   // interrupt request
   output logic                   irq
);

   // address decode shared by reads and writes
   function automatic rtcc_sel_e rtcc_decode(input logic [ADDR_W-1:0] addr);
      logic [7:0] a;
      a = 8'(addr) & 8'hFC;
      case (a)
         `RTCC_OFS_HOUR_MINUTE:  rtcc_decode = RTCC_SEL_HOUR_MINUTE;
         `RTCC_OFS_MONTH_DAY:    rtcc_decode = RTCC_SEL_MONTH_DAY;
         `RTCC_OFS_YEAR_WEEKDAY: rtcc_decode = RTCC_SEL_YEAR_WEEKDAY;
         `RTCC_OFS_IRQ_FLAGS:    rtcc_decode = RTCC_SEL_FLAGS;
         `RTCC_OFS_IRQ_ENABLES:  rtcc_decode = RTCC_SEL_ENABLES;
         default:                rtcc_decode = RTCC_SEL_NONE;
      endcase
   endfunction : rtcc_decode

   // merge the two low byte lanes of a write into an old value
   function automatic logic [15:0] rtcc_merge(input logic [15:0] old_val,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb);
      rtcc_merge[7:0]  = strb[0] ? data[7:0]  : old_val[7:0];
      rtcc_merge[15:8] = strb[1] ? data[15:8] : old_val[15:8];
   endfunction : rtcc_merge

   // last day of a month in bcd, leap taken from the year digits
   function automatic logic [5:0] rtcc_last_day(input logic       mon_tens,
                                                input logic [3:0] mon_units,
                                                input logic [3:0] yr_tens,
                                                input logic [3:0] yr_units);
      logic leap;
      leap = yr_tens[0] ? (yr_units == 4'h2 || yr_units == 4'h6)
                        : (yr_units == 4'h0 || yr_units == 4'h4 || yr_units == 4'h8);
      if (!mon_tens && mon_units == 4'h2)
         rtcc_last_day = leap ? 6'h29 : 6'h28; // R8
      else if ((!mon_tens && (mon_units == 4'h4 || mon_units == 4'h6 ||
                mon_units == 4'h9)) || (mon_tens && mon_units == 4'h1))
         rtcc_last_day = 6'h30; // R8
      else
         rtcc_last_day = 6'h31; // R8
   endfunction : rtcc_last_day

   // counter and register state
   rtcc_time_s        time_now;
   rtcc_date_s        date_now;
   rtcc_year_s        year_now;
   logic [15:0]       clock_irq_flags;
   logic [15:0]       clock_irq_enables;

   // next values of the carry chain
   rtcc_time_s        next_time;
   rtcc_date_s        next_date;
   rtcc_year_s        next_year;
   logic              hour_roll;
   logic              day_roll;

   // bus holding state
   logic              aw_full;
   logic              w_full;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0]       w_data;
   logic [3:0]        w_strb;
   logic              do_write;
   rtcc_sel_e         wr_sel;
   logic [15:0]       rd_word;
   logic [15:0]       hm_word;
   logic [15:0]       md_word;
   logic [15:0]       yw_word;
   logic [15:0]       hm_new;
   logic [15:0]       md_new;
   logic [15:0]       yw_new;
   logic [15:0]       set_vec;
   logic [15:0]       clr_vec;

   // packed register views
   assign hm_word = {1'b0, time_now.pm, time_now.hour_tens, time_now.hour_units,
                     1'b0, time_now.minute_tens, time_now.minute_units};
   assign md_word = {3'h0, date_now.month_tens, date_now.month_units,
                     2'h0, date_now.day_tens, date_now.day_units};
   assign yw_word = {5'h00, year_now.weekday_count, year_now.year_tens,
                     year_now.year_units};

   // minute to year carry chain, evaluated on each minute step
   always_comb
   begin
      next_time = time_now;
      next_date = date_now;
      next_year = year_now;
      hour_roll = 1'b0;
      day_roll  = 1'b0;
      // minute 00..59
      if (time_now.minute_units == 4'h9) // R5
      begin
         next_time.minute_units = 4'h0;
         if (time_now.minute_tens == 3'h5)
         begin
            next_time.minute_tens = 3'h0;
            hour_roll             = 1'b1; // R18
         end
         else
            next_time.minute_tens = time_now.minute_tens + 3'h1;
      end
      else
         next_time.minute_units = time_now.minute_units + 4'h1;
      // hour step in either mode
      if (hour_roll)
      begin
         if (hour24_select)
         begin
            next_time.pm = 1'b0; // R3
            if (time_now.hour_tens == 2'h2 && time_now.hour_units == 4'h3) // R4
            begin
               next_time.hour_tens  = 2'h0;
               next_time.hour_units = 4'h0;
               day_roll             = 1'b1; // R18
            end
            else if (time_now.hour_units == 4'h9)
            begin
               next_time.hour_tens  = time_now.hour_tens + 2'h1;
               next_time.hour_units = 4'h0;
            end
            else
               next_time.hour_units = time_now.hour_units + 4'h1;
         end
         else
         begin
            if (time_now.hour_tens == 2'h1 && time_now.hour_units == 4'h2) // R4
            begin
               next_time.hour_tens  = 2'h0;
               next_time.hour_units = 4'h1;
            end
            else if (time_now.hour_tens == 2'h1 && time_now.hour_units == 4'h1)
            begin
               // eleven to twelve flips the half of the day
               next_time.hour_units = 4'h2;
               next_time.pm         = ~time_now.pm; // R1
               day_roll             = time_now.pm; // R18
            end
            else if (time_now.hour_units == 4'h9)
            begin
               next_time.hour_tens  = 2'h1;
               next_time.hour_units = 4'h0;
            end
            else
               next_time.hour_units = time_now.hour_units + 4'h1;
         end
      end
      // day, weekday, month and year
      if (day_roll)
      begin
         if (year_now.weekday_count >= `RTCC_WEEKDAY_SATURDAY) // R9 R10
            next_year.weekday_count = `RTCC_WEEKDAY_SUNDAY;
         else
            next_year.weekday_count = year_now.weekday_count + 3'h1;
         if ({date_now.day_tens, date_now.day_units} >=
             rtcc_last_day(date_now.month_tens, date_now.month_units,
                           year_now.year_tens, year_now.year_units)) // R8
         begin
            next_date.day_tens  = 2'h0;
            next_date.day_units = 4'h1;
            if (date_now.month_tens && date_now.month_units == 4'h2) // R7
            begin
               next_date.month_tens  = 1'b0;
               next_date.month_units = 4'h1;
               if (year_now.year_units == 4'h9) // R11
               begin
                  next_year.year_units = 4'h0;
                  next_year.year_tens  = (year_now.year_tens == 4'h9) ? 4'h0
                                         : year_now.year_tens + 4'h1;
               end
               else
                  next_year.year_units = year_now.year_units + 4'h1;
            end
            else if (date_now.month_units == 4'h9)
            begin
               next_date.month_tens  = 1'b1;
               next_date.month_units = 4'h0;
            end
            else
               next_date.month_units = date_now.month_units + 4'h1;
         end
         else if (date_now.day_units == 4'h9)
         begin
            next_date.day_tens  = date_now.day_tens + 2'h1;
            next_date.day_units = 4'h0;
         end
         else
            next_date.day_units = date_now.day_units + 4'h1;
      end
   end

   // software write to the hour/minute word, pm guarded in 24-hour mode
   always_comb
   begin
      hm_new = rtcc_merge(hm_word, w_data, w_strb);
      if (hour24_select && !(hm_new[`RTCC_PM_BIT] && hm_word[`RTCC_PM_BIT]))
         hm_new[`RTCC_PM_BIT] = 1'b0; // R2
   end

   // merged write words for the date registers, byte lanes applied once
   assign md_new = rtcc_merge(md_word, w_data, w_strb);
   assign yw_new = rtcc_merge(yw_word, w_data, w_strb);

   // counters: a bus write takes precedence over a step in the same cycle;
   // software is expected to stay off the digits while busy, so the busy
   // input is not used to block anything here
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         time_now <= '{pm: 1'b0, hour_tens: `RTCC_RST_HOUR_TENS,
                       hour_units: `RTCC_RST_HOUR_UNITS,
                       minute_tens: 3'h0, minute_units: 4'h0};
         date_now <= '{month_tens: 1'b0, month_units: `RTCC_RST_MONTH_UNITS,
                       day_tens: 2'h0, day_units: `RTCC_RST_DAY_UNITS};
         year_now <= '{weekday_count: 3'h0, year_tens: 4'h0, year_units: 4'h0};
      end
      else
      begin
         if (events.minute_step)
         begin
            time_now <= next_time; // R18
            date_now <= next_date;
            year_now <= next_year;
         end
         if (do_write && wr_sel == RTCC_SEL_HOUR_MINUTE) // R6
         begin
            time_now.pm           <= hm_new[`RTCC_PM_BIT]; // R1 R2
            time_now.hour_tens    <= hm_new[`RTCC_HOUR_TENS_LSB +: 2]; // R4
            time_now.hour_units   <= hm_new[`RTCC_HOUR_UNITS_LSB +: 4];
            time_now.minute_tens  <= hm_new[`RTCC_MIN_TENS_LSB +: 3]; // R5
            time_now.minute_units <= hm_new[`RTCC_MIN_UNITS_LSB +: 4];
         end
         if (do_write && wr_sel == RTCC_SEL_MONTH_DAY)
         begin
            date_now <= rtcc_date_s'({md_new[`RTCC_MONTH_TENS_BIT -: 5],
                                      md_new[`RTCC_DAY_TENS_LSB + 1 : 0]}); // R7 R8
         end
         if (do_write && wr_sel == RTCC_SEL_YEAR_WEEKDAY)
         begin
            year_now <= rtcc_year_s'(yw_new[`RTCC_WEEKDAY_LSB + 2 : 0]); // R9 R11
         end
      end
   end

   // flag sources and software clears
   always_comb
   begin
      set_vec = 16'h0000;
      set_vec[`RTCC_FLAG_REGULATION]   = events.regulation_done; // R13
      set_vec[`RTCC_FLAG_SW1HZ]        = events.stopwatch_1hz;
      set_vec[`RTCC_FLAG_SW10HZ]       = events.stopwatch_10hz;
      set_vec[`RTCC_FLAG_SW100HZ]      = events.stopwatch_100hz;
      set_vec[`RTCC_FLAG_ALARM]        = events.alarm_match; // R14
      set_vec[`RTCC_FLAG_DAY]          = events.minute_step & day_roll;
      set_vec[`RTCC_FLAG_HOUR]         = events.minute_step & hour_roll;
      set_vec[`RTCC_FLAG_MINUTE]       = events.minute_step;
      set_vec[`RTCC_FLAG_SECOND]       = events.second_tick;
      set_vec[`RTCC_FLAG_HALF]         = events.half_second;
      set_vec[`RTCC_FLAG_QUARTER]      = events.quarter_second;
      set_vec[`RTCC_FLAG_EIGHTH]       = events.eighth_second;
      set_vec[`RTCC_FLAG_THIRTYSECOND] = events.thirtysecond_second;
      clr_vec = 16'h0000;
      if (do_write && wr_sel == RTCC_SEL_FLAGS)
         clr_vec = rtcc_merge(16'h0000, w_data, w_strb);
   end

   // sticky flags: an event in the clearing cycle survives
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         clock_irq_flags <= 16'h0000;
      else
         clock_irq_flags <= ((clock_irq_flags & ~clr_vec) | set_vec)
                            & `RTCC_FLAG_MASK; // R12 R13 R14
   end

   // enables, plain read/write at the flag positions
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         clock_irq_enables <= 16'h0000;
      else if (do_write && wr_sel == RTCC_SEL_ENABLES)
         clock_irq_enables <= rtcc_merge(clock_irq_enables, w_data, w_strb)
                              & `RTCC_FLAG_MASK; // R15 R16
   end

   // interrupt request, registered so it lags the flag by one cycle
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         irq <= 1'b0;
      else
         irq <= |(clock_irq_flags & clock_irq_enables); // R17
   end

   // write address channel, held until the response is taken
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         awready <= 1'b0;
         aw_full <= 1'b0;
         aw_addr <= '0;
      end
      else if (awvalid && awready)
      begin
         awready <= 1'b0;
         aw_full <= 1'b1;
         aw_addr <= awaddr;
      end
      else if (bvalid && bready)
      begin
         awready <= 1'b1;
         aw_full <= 1'b0;
      end
      else if (!aw_full && !bvalid)
         awready <= 1'b1;
   end

   // write data channel, independent of the address
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         wready <= 1'b0;
         w_full <= 1'b0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
      end
      else if (wvalid && wready)
      begin
         wready <= 1'b0;
         w_full <= 1'b1;
         w_data <= wdata;
         w_strb <= wstrb;
      end
      else if (bvalid && bready)
      begin
         wready <= 1'b1;
         w_full <= 1'b0;
      end
      else if (!w_full && !bvalid)
         wready <= 1'b1;
   end

   // write takes effect once both halves are held
   assign do_write = aw_full & w_full & ~bvalid;
   assign wr_sel   = rtcc_decode(aw_addr);

   // write response; unmapped addresses answer slverr and change nothing
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         bvalid <= 1'b0;
         bresp  <= `RTCC_RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid <= 1'b1;
         bresp  <= (wr_sel == RTCC_SEL_NONE) ? `RTCC_RESP_SLVERR : `RTCC_RESP_OKAY;
      end
      else if (bvalid && bready)
         bvalid <= 1'b0;
   end

   // read multiplexer
   always_comb
   begin
      case (rtcc_decode(araddr))
         RTCC_SEL_HOUR_MINUTE:  rd_word = hm_word;
         RTCC_SEL_MONTH_DAY:    rd_word = md_word;
         RTCC_SEL_YEAR_WEEKDAY: rd_word = yw_word;
         RTCC_SEL_FLAGS:        rd_word = clock_irq_flags;
         RTCC_SEL_ENABLES:      rd_word = clock_irq_enables;
         default:               rd_word = 16'h0000;
      endcase
   end

   // read channel, one outstanding read, data sampled at acceptance
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h00000000;
         rresp   <= `RTCC_RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= {16'h0000, rd_word};
         rresp   <= (rtcc_decode(araddr) == RTCC_SEL_NONE) ? `RTCC_RESP_SLVERR
                                                           : `RTCC_RESP_OKAY;
      end
      else if (rvalid && rready)
      begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
      else if (!rvalid)
         arready <= 1'b1;
   end

endmodule : rtcc_calendar
`default_nettype wire

/* File: testbench/rtcc_calendar_sva.sv */
// bus and interrupt checker for the calendar block
`timescale 1ns/100ps
`default_nettype none
module rtcc_calendar_sva
   import rtcc_pkg::*;
(
   // clock and reset
   input wire logic         clk,
   input wire logic         reset,
   // bus handshakes
   input wire logic         awvalid,
   input wire logic         awready,
   input wire logic         wvalid,
   input wire logic         wready,
   input wire logic         bvalid,
   input wire logic         bready,
   input wire logic         arvalid,
   input wire logic         arready,
   input wire logic         rvalid,
   input wire logic         rready,
   input wire logic [31:0]  rdata,
   // events and interrupt
   input wire rtcc_events_s events,
   input wire logic         irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // write channel: one at a time, answer two edges on
   aw_busy_a: assert property (awvalid && awready |=> !awready)
      else $error("awready high after address taken");
   b_latency_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
      else $error("write response late");
   b_hold_a: assert property (bvalid && !bready |=> bvalid)
      else $error("bvalid dropped before bready");
   // read channel
   r_latency_a: assert property (arvalid && arready |=> rvalid && !arready)
      else $error("read data not offered next cycle");
   r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data changed before rready");
   r_upper_a: assert property (rvalid |-> rdata[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   // irq rises only from an event or a register write
   irq_rise_a: assert property ($rose(irq) |-> $past(|events, 2) || $past(bvalid))
      else $error("irq rose without cause");
   // irq only drops after a register write
   irq_fall_a: assert property ($fell(irq) |-> $past(bvalid))
      else $error("irq fell without a write");
endmodule : rtcc_calendar_sva

bind rtcc_calendar rtcc_calendar_sva i_rtcc_calendar_sva (.clk, .reset, .awvalid, .awready,
   .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .rdata,
   .events, .irq);
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the calendar block
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import rtcc_pkg::*;
   // stimulus and observed ports
   logic         clk = 1'b0, reset = 1'b1, hour24_select = 1'b0;
   logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic         arvalid = 1'b0, rready = 1'b0;
   logic [7:0]   awaddr = 8'h00, araddr = 8'h00;
   logic [31:0]  wdata = 32'h0, rdata;
   logic [3:0]   wstrb = 4'hF;
   logic [1:0]   bresp, rresp;
   logic         awready, wready, bvalid, arready, rvalid, irq;
   rtcc_events_s events = '0;
   int           failures = 0, n_tests = 0;
   // flag position per event bit, lsb first
   int           fpos[11] = '{0, 1, 2, 3, 4, 5, 8, 12, 13, 14, 15};
   // year/weekday, month/day, then expected month/day and year/weekday
   logic [15:0]  dt[4][4] = '{'{16'h0601, 16'h0228, 16'h0301, 16'h0001},
      '{16'h0004, 16'h0228, 16'h0229, 16'h0104}, '{16'h0000, 16'h0430, 16'h0501, 16'h0100},
      '{16'h0399, 16'h1231, 16'h0101, 16'h0400}};

   always #10 clk = ~clk;

   rtcc_calendar i_rtcc_calendar (.clk, .reset, .awvalid, .awready, .awaddr, .awprot(3'h0),
      .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
      .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .hour24_select,
      .clock_busy_status(1'b0), .events, .irq);

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic complete_run;
      $display("failures %0d tests %0d", failures, n_tests);
      if (failures == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : complete_run

   // bounded edge wait, a hang ends the run
   task automatic step(inout int n);
      @(posedge clk);
      n++;
      if (n > 40)
      begin
         failures++;
         $display("mismatch %0t bus timeout", $time);
         complete_run();
      end
   endtask : step

   // lag holds bready low for that many edges so the response must wait
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er = 2'h0,
                     input int lag = 0);
      int n = 0;
      awaddr <= a;
      wdata <= {16'h0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= (lag == 0);
      do
      begin
         step(n);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (n == lag) bready <= 1'b1;
         if (bready && bvalid)
         begin
            bready <= 1'b0;
            chk(32'(bresp), 32'(er));
         end
      end
      while (awvalid || wvalid || bready || n <= lag);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er = 2'h0,
                     input int lag = 0);
      int n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= (lag == 0);
      do
      begin
         step(n);
         if (arvalid && arready) arvalid <= 1'b0;
         if (n == lag) rready <= 1'b1;
         if (rready && rvalid)
         begin
            rready <= 1'b0;
            chk(rdata, {16'h0000, e});
            chk(32'(rresp), 32'(er));
         end
      end
      while (arvalid || rready || n <= lag);
   endtask : rd

   // one-cycle event pulse
   task automatic ev(input int i);
      events <= rtcc_events_s'(11'h001 << i);
      @(posedge clk);
      events <= '0;
      @(posedge clk);
   endtask : ev

   task automatic t_reset;
      rd(8'h00, 16'h1200);
      rd(8'h04, 16'h0101);
      rd(8'h08, 16'h0000);
      rd(8'h0C, 16'h0000);
      rd(8'h10, 16'h0000, 2'h0, 2);
      wr(8'h14, 16'hFFFF, 2'h2, 3);
      rd(8'h14, 16'h0000, 2'h2);
   endtask : t_reset

   // 12-hour roll at pm 11:59, then mode switch with pm set
   task automatic t_twelve;
      wr(8'h00, 16'h5159);
      rd(8'h00, 16'h5159);
      ev(5);
      rd(8'h00, 16'h1200);
      rd(8'h04, 16'h0102);
      rd(8'h08, 16'h0100);
      rd(8'h0C, 16'h00E0);
      wr(8'h00, 16'h1259);
      ev(5);
      rd(8'h00, 16'h0100);
      wr(8'h00, 16'h4159);
      hour24_select <= 1'b1;
      rd(8'h00, 16'h4159);
      ev(5);
      rd(8'h00, 16'h0200);
      wr(8'h00, 16'h5000);
      rd(8'h00, 16'h1000);
      wstrb <= 4'h2;
      wr(8'h00, 16'h0955);
      wstrb <= 4'hF;
      rd(8'h00, 16'h0900);
   endtask : t_twelve

   // day, month and year limits in 24-hour mode
   task automatic t_days;
      for (int k = 0; k < 4; k++)
      begin
         wr(8'h08, dt[k][0]);
         wr(8'h04, dt[k][1]);
         wr(8'h00, 16'h2359);
         ev(5);
         rd(8'h00, 16'h0000);
         rd(8'h04, dt[k][2]);
         rd(8'h08, dt[k][3]);
      end
   endtask : t_days

   // sticky flags, enables and interrupt gating
   task automatic t_flags;
      logic [15:0] e;
      e = 16'h0000;
      wr(8'h0C, 16'hFFFF);
      for (int i = 0; i < 11; i++)
      begin
         ev(i);
         e = e | (16'h0001 << fpos[i]);
         rd(8'h0C, e);
      end
      wr(8'h0C, 16'h0000);
      rd(8'h0C, 16'hF13F);
      wr(8'h10, 16'hFFFF);
      rd(8'h10, 16'hF1FF);
      chk(32'(irq), 32'h1);
      wr(8'h0C, 16'hFFFE);
      rd(8'h0C, 16'h0001);
      wr(8'h10, 16'h0002);
      chk(32'(irq), 32'h0);
      wr(8'h10, 16'h0001);
      chk(32'(irq), 32'h1);
      wr(8'h0C, 16'h0001);
      chk(32'(irq), 32'h0);
   endtask : t_flags

   // reset, then the scenarios in turn
   initial
   begin
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(posedge clk);
      t_reset();
      t_twelve();
      t_days();
      t_flags();
      complete_run();
   end
endmodule : testbench
`default_nettype wire
